/* core/mcu_core_map.vh */
`ifndef MCU_CORE_MAP_VH
`define MCU_CORE_MAP_VH

`define ROM_DEPTH        1024
`define ROM_AW           10
`define RAM_DEPTH        64
`define RAM_AW           6
`define PC_RESET         10'h000

// commands
`define CMD_NOP          5'h00
`define CMD_FETCH        5'h01
`define CMD_JUMP         5'h02
`define CMD_CALL         5'h03
`define CMD_RET          5'h04
`define CMD_LD_HIGH      5'h05
`define CMD_LD_LOW       5'h06
`define CMD_LD_ACC       5'h07
`define CMD_RD_DIR       5'h08
`define CMD_WR_DIR       5'h09
`define CMD_RD_PTR       5'h0A
`define CMD_WR_PTR       5'h0B
`define CMD_RD_PTR_INC   5'h0C
`define CMD_RD_PTR_DEC   5'h0D
`define CMD_RD_STACK     5'h0E
`define CMD_WR_STACK     5'h0F
`define CMD_SP_LOAD      5'h10
`define CMD_ALU          5'h11
`define CMD_PAIR_INC     5'h12
`define CMD_PORT_RD      5'h13
`define CMD_PORT_WR      5'h14
`define CMD_PORT_BSET    5'h15
`define CMD_PORT_BCLR    5'h16
`define CMD_SKIP_CLR     5'h17

// alu operations
`define ALU_ADDC         4'h0
`define ALU_AND          4'h1
`define ALU_OR           4'h2
`define ALU_XOR          4'h3
`define ALU_INC          4'h4
`define ALU_DEC          4'h5
`define ALU_CMP          4'h6
`define ALU_BSET         4'h7
`define ALU_BCLR         4'h8
`define ALU_SETC         4'h9
`define ALU_CLRC         4'hA

// port selects held in the low pointer
`define SEL_PORT0        4'h0
`define SEL_SMODE        4'h1
`define SEL_SIO_LO       4'h2
`define SEL_SIO_HI       4'h3
`define SEL_PORT8        4'h8
`define SEL_PORT10       4'hA
`define SEL_PORT11       4'hB
`define BSEL_PORT8       2'h1
`define BSEL_PORT10      2'h2
`define BSEL_PORT11      2'h3

// status word bit positions
`define PSW_CARRY        0
`define PSW_ZERO         1
`define PSW_SKIP_LOW     2
`define PSW_SKIP_HIGH    3

// serial pin positions on port 0
`define SER_SCK_BIT      1
`define SER_OUT_BIT      2
`define SER_IN_BIT       3

`endif

/* core/alu4.v */
`timescale 1ns/1ps
`include "mcu_core_map.vh"

module alu4 (
    input  wire [3:0] op_in,
    input  wire [3:0] a_in,
    input  wire [3:0] b_in,
    input  wire       carry_in,
    input  wire [1:0] bit_sel_in,
    output reg  [3:0] result_out,
    output reg        carry_out,
    output reg        skip_out,
    output reg        acc_dest_out
);

    reg [4:0] sum;

    always @* begin
        sum          = {1'b0, a_in} + {1'b0, b_in} + {4'h0, carry_in};
        result_out   = a_in;
        carry_out    = carry_in;
        skip_out     = 1'b0;
        acc_dest_out = 1'b1;
        case (op_in)
            `ALU_ADDC: begin
                result_out = sum[3:0];
                carry_out  = sum[4];
                skip_out   = sum[4];
            end
            `ALU_AND: result_out = a_in & b_in;
            `ALU_OR:  result_out = a_in | b_in;
            `ALU_XOR: result_out = a_in ^ b_in;
            `ALU_INC: begin
                result_out = a_in + 4'h1;
                skip_out   = (a_in == 4'hF);
            end
            `ALU_DEC: begin
                result_out = a_in - 4'h1;
                skip_out   = (a_in == 4'h0);
            end
            `ALU_CMP: skip_out = (a_in == b_in);
            `ALU_BSET: begin
                result_out   = b_in | (4'h1 << bit_sel_in);
                acc_dest_out = 1'b0;
            end
            `ALU_BCLR: begin
                result_out   = b_in & ~(4'h1 << bit_sel_in);
                acc_dest_out = 1'b0;
            end
            `ALU_SETC: carry_out = 1'b1;
            `ALU_CLRC: carry_out = 1'b0;
            default: result_out = a_in;
        endcase
    end

endmodule // alu4

/* core/mcu_core_datapath.v */
`timescale 1ns/1ps
`include "mcu_core_map.vh"

module mcu_core_datapath #(
    parameter P8_BIT3_IS_OSC   = 0,
    parameter BIDIR_PUSH_PULL  = 0
) (
    input  wire        clock_in,
    input  wire        rst_in,
    input  wire        cmd_valid_in,
    input  wire [4:0]  cmd_in,
    input  wire [7:0]  imm_in,
    input  wire [9:0]  target_in,
    input  wire [3:0]  alu_op_in,
    input  wire        rom_wr_en_in,
    input  wire [9:0]  rom_wr_addr_in,
    input  wire [7:0]  rom_wr_data_in,
    input  wire [3:0]  port0_in,
    input  wire [3:0]  port10_in,
    input  wire [3:0]  port11_in,
    output reg  [7:0]  instr_out,
    output reg  [9:0]  pc_out,
    output reg  [3:0]  acc_out,
    output reg  [5:0]  pointer_out,
    output reg  [5:0]  sp_out,
    output reg  [3:0]  psw_out,
    output reg  [3:0]  mem_data_out,
    output reg         busy_out,
    output reg         serial_mode_out,
    output reg         serial_done_out,
    output reg  [3:0]  port0_out,
    output reg  [3:0]  port0_oe_out,
    output reg  [3:0]  port8_out,
    output reg  [3:0]  port8_oe_out,
    output reg  [3:0]  port10_out,
    output reg  [3:0]  port10_oe_out,
    output reg  [3:0]  port11_out,
    output reg  [3:0]  port11_oe_out
);

    localparam ST_IDLE = 2'h0;
    localparam ST_CALL = 2'h1;
    localparam ST_RET  = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // storage

    reg [7:0] rom [0:`ROM_DEPTH-1];
    reg [3:0] ram [0:`RAM_DEPTH-1];

    reg [1:0] high_q;
    reg [3:0] low_q;
    reg [3:0] acc_q;
    reg [9:0] pc_q;
    reg [9:0] target_q;
    reg [5:0] sp_q;
    reg       carry_q;
    reg       skip_low_q;
    reg       skip_high_q;
    reg [1:0] state_q;
    reg [1:0] step_q;
    reg [7:0] sio_q;
    reg [2:0] bit_cnt_q;
    reg       sck_prev_q;
    reg [3:0] p8_latch_q;
    reg [3:0] p10_latch_q;
    reg [3:0] p11_latch_q;

    wire [5:0] ptr    = {high_q, low_q};
    wire [3:0] mem_hl = ram[ptr];
    wire [3:0] program_status_word    = {skip_high_q, skip_low_q, 1'b0, carry_q};
    wire       take   = cmd_valid_in && (state_q == ST_IDLE);

    wire [3:0] alu_y;
    wire       alu_c;
    wire       alu_skip;
    wire       alu_to_acc;

    alu4 u_alu (
        .op_in        (alu_op_in),
        .a_in         (acc_q),
        .b_in         (mem_hl),
        .carry_in     (carry_q),
        .bit_sel_in   (imm_in[1:0]),
        .result_out   (alu_y),
        .carry_out    (alu_c),
        .skip_out     (alu_skip),
        .acc_dest_out (alu_to_acc)
    );

    // open drain: a latched one releases the pin
    function [3:0] bidir_oe;
        input [3:0] latch;
        begin
            bidir_oe = (BIDIR_PUSH_PULL != 0) ? 4'hF : ~latch;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // sequencing and commands

    reg [3:0] push_word;
    reg [8:0] pair_sum;
    reg [3:0] port_rd;

    always @* begin
        case (step_q)
            2'h0:    push_word = {2'h0, pc_q[9:8]};
            2'h1:    push_word = pc_q[7:4];
            2'h2:    push_word = pc_q[3:0];
            default: push_word = program_status_word;
        endcase
        pair_sum = {1'b0, mem_hl, acc_q} + 9'h001;
        case (low_q)
            `SEL_PORT0:  port_rd = port0_in;
            `SEL_SMODE:  port_rd = {3'h0, serial_mode_out};
            `SEL_SIO_LO: port_rd = sio_q[3:0];
            `SEL_SIO_HI: port_rd = sio_q[7:4];
            `SEL_PORT8:  port_rd = p8_latch_q;
            `SEL_PORT10: port_rd = port10_in;
            `SEL_PORT11: port_rd = port11_in;
            default:     port_rd = 4'h0;
        endcase
    end

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc_q        <= `PC_RESET;
            instr_out   <= 8'h00;
            high_q      <= 2'h0;
            low_q       <= 4'h0;
            acc_q       <= 4'h0;
            target_q    <= 10'h000;
            sp_q        <= 6'h00;
            carry_q     <= 1'b0;
            skip_low_q  <= 1'b0;
            skip_high_q <= 1'b0;
            state_q     <= ST_IDLE;
            step_q      <= 2'h0;
        end else begin
            case (state_q)
                ST_CALL: begin
                    step_q <= step_q + 2'h1;
                    if (step_q == 2'h3) begin
                        pc_q    <= target_q;
                        state_q <= ST_IDLE;
                    end else begin
                        sp_q <= sp_q - 6'h01;
                    end
                end
                ST_RET: begin
                    // psw slot skipped: flags stay
                    step_q <= step_q + 2'h1;
                    sp_q   <= sp_q + 6'h01;
                    case (step_q)
                        2'h1: pc_q[3:0] <= ram[sp_q];
                        2'h2: pc_q[7:4] <= ram[sp_q];
                        2'h3: begin
                            pc_q[9:8] <= ram[sp_q][1:0];
                            state_q   <= ST_IDLE;
                        end
                        default: pc_q <= pc_q;
                    endcase
                end
                ST_IDLE: if (take) begin
                    case (cmd_in)
                        `CMD_FETCH: begin
                            instr_out <= rom[pc_q];
                            pc_q      <= pc_q + 10'h001;
                        end
                        `CMD_JUMP: pc_q <= target_in;
                        `CMD_CALL: begin
                            target_q <= target_in;
                            sp_q     <= sp_q - 6'h01;
                            step_q   <= 2'h0;
                            state_q  <= ST_CALL;
                        end
                        `CMD_RET: begin
                            sp_q    <= sp_q + 6'h01;
                            step_q  <= 2'h1;
                            state_q <= ST_RET;
                        end
                        `CMD_LD_HIGH: high_q <= imm_in[1:0];
                        `CMD_LD_LOW:  low_q  <= imm_in[3:0];
                        `CMD_LD_ACC: begin
                            acc_q       <= imm_in[3:0];
                            skip_high_q <= 1'b1;
                        end
                        `CMD_RD_DIR:   acc_q <= ram[imm_in[5:0]];
                        `CMD_RD_PTR:   acc_q <= mem_hl;
                        `CMD_RD_STACK: acc_q <= ram[sp_q];
                        `CMD_RD_PTR_INC: begin
                            acc_q              <= mem_hl;
                            {high_q, low_q}    <= ptr + 6'h01;
                            skip_low_q         <= (ptr == 6'h3F);
                        end
                        `CMD_RD_PTR_DEC: begin
                            acc_q              <= mem_hl;
                            {high_q, low_q}    <= ptr - 6'h01;
                            skip_low_q         <= (ptr == 6'h00);
                        end
                        `CMD_SP_LOAD: sp_q <= {mem_hl[1:0], acc_q};
                        `CMD_ALU: begin
                            if (alu_to_acc)
                                acc_q <= alu_y;
                            carry_q    <= alu_c;
                            skip_low_q <= alu_skip;
                        end
                        `CMD_PAIR_INC: begin
                            acc_q      <= pair_sum[3:0];
                            carry_q    <= pair_sum[8];
                            skip_low_q <= pair_sum[8];
                        end
                        `CMD_PORT_RD: acc_q <= port_rd;
                        `CMD_SKIP_CLR: begin
                            skip_low_q  <= 1'b0;
                            skip_high_q <= 1'b0;
                        end
                        default: acc_q <= acc_q;
                    endcase
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory writes; arrays unreset

    always @(posedge clock_in) begin
        if (rom_wr_en_in)
            rom[rom_wr_addr_in] <= rom_wr_data_in;
        if (state_q == ST_CALL)
            ram[sp_q] <= push_word;
        else if (take) begin
            case (cmd_in)
                `CMD_WR_DIR:   ram[imm_in[5:0]] <= acc_q;
                `CMD_WR_PTR:   ram[ptr] <= acc_q;
                `CMD_WR_STACK: ram[sp_q] <= acc_q;
                `CMD_ALU:      if (!alu_to_acc) ram[ptr] <= alu_y;
                `CMD_PAIR_INC: ram[ptr] <= pair_sum[7:4];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ports and serial interface

    wire wr_port = take && (cmd_in == `CMD_PORT_WR);
    wire bset    = take && (cmd_in == `CMD_PORT_BSET);
    wire bclr    = take && (cmd_in == `CMD_PORT_BCLR);
    wire bit_op  = bset || bclr;
    wire [3:0] bit_mask = 4'h1 << low_q[1:0];
    wire sck_in  = port0_in[`SER_SCK_BIT];
    wire sck_fall = serial_mode_out && sck_prev_q && !sck_in;
    wire sck_rise = serial_mode_out && !sck_prev_q && sck_in;

    reg [3:0] p8_d;
    reg [3:0] p10_d;
    reg [3:0] p11_d;

    always @* begin
        p8_d  = p8_latch_q;
        p10_d = p10_latch_q;
        p11_d = p11_latch_q;
        if (wr_port) begin
            if (low_q == `SEL_PORT8)  p8_d  = acc_q;
            if (low_q == `SEL_PORT10) p10_d = acc_q;
            if (low_q == `SEL_PORT11) p11_d = acc_q;
        end
        if (bit_op) begin
            if (low_q[3:2] == `BSEL_PORT8)
                p8_d = bset ? (p8_latch_q | bit_mask) : (p8_latch_q & ~bit_mask);
            if (low_q[3:2] == `BSEL_PORT10)
                p10_d = bset ? (p10_latch_q | bit_mask) : (p10_latch_q & ~bit_mask);
            if (low_q[3:2] == `BSEL_PORT11)
                p11_d = bset ? (p11_latch_q | bit_mask) : (p11_latch_q & ~bit_mask);
        end
    end

    wire p8_touch = (wr_port && low_q == `SEL_PORT8) ||
                    (bit_op && low_q[3:2] == `BSEL_PORT8);

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            p8_latch_q      <= 4'h0;
            p10_latch_q     <= 4'hF;
            p11_latch_q     <= 4'hF;
            port8_out       <= 4'h0;
            port8_oe_out    <= 4'h0;
            port10_out      <= 4'hF;
            port11_out      <= 4'hF;
            port10_oe_out   <= (BIDIR_PUSH_PULL != 0) ? 4'hF : 4'h0;
            port11_oe_out   <= (BIDIR_PUSH_PULL != 0) ? 4'hF : 4'h0;
            serial_mode_out <= 1'b0;
            serial_done_out <= 1'b0;
            port0_out       <= 4'h0;
            port0_oe_out    <= 4'h0;
            sio_q           <= 8'h00;
            bit_cnt_q       <= 3'h0;
            sck_prev_q      <= 1'b1;
        end else begin
            p8_latch_q    <= p8_d;
            p10_latch_q   <= p10_d;
            p11_latch_q   <= p11_d;
            port8_out     <= p8_d;
            if (p8_touch) begin
                // bit 3 off as oscillator pin
                port8_oe_out <= (P8_BIT3_IS_OSC != 0) ? 4'h7 : 4'hF;
            end
            port10_out    <= p10_d;
            port11_out    <= p11_d;
            port10_oe_out <= bidir_oe(p10_d);
            port11_oe_out <= bidir_oe(p11_d);
            sck_prev_q    <= sck_in;
            if (wr_port && low_q == `SEL_SMODE) begin
                serial_mode_out <= acc_q[0];
                port0_oe_out    <= acc_q[0] ? (4'h1 << `SER_OUT_BIT) : 4'h0;
                bit_cnt_q       <= 3'h0;
            end
            if (wr_port && low_q == `SEL_SIO_LO) begin
                sio_q[3:0]      <= acc_q;
                serial_done_out <= 1'b0;
            end else if (wr_port && low_q == `SEL_SIO_HI) begin
                sio_q[7:4]      <= acc_q;
                serial_done_out <= 1'b0;
            end else begin
                // out on fall, in on rise
                if (sck_fall)
                    port0_out[`SER_OUT_BIT] <= sio_q[7];
                if (sck_rise) begin
                    sio_q     <= {sio_q[6:0], port0_in[`SER_IN_BIT]};
                    bit_cnt_q <= bit_cnt_q + 3'h1;
                    if (bit_cnt_q == 3'h7)
                        serial_done_out <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered views

    always @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            pc_out       <= `PC_RESET;
            acc_out      <= 4'h0;
            pointer_out  <= 6'h00;
            sp_out       <= 6'h00;
            psw_out      <= 4'h0;
            mem_data_out <= 4'h0;
            busy_out     <= 1'b0;
        end else begin
            pc_out       <= pc_q;
            acc_out      <= acc_q;
            pointer_out  <= ptr;
            sp_out       <= sp_q;
            psw_out      <= program_status_word;
            mem_data_out <= mem_hl;
            busy_out     <= (state_q != ST_IDLE) || (take &&
                            (cmd_in == `CMD_CALL || cmd_in == `CMD_RET));
        end
    end

endmodule // mcu_core_datapath

/* test/mcu_core_datapath_props.sv */
`timescale 1ns/1ps
`include "mcu_core_map.vh"

module datapath_props (
    input wire       clock_in,
    input wire       rst_in,
    input wire       cmd_valid_in,
    input wire       busy_out,
    input wire [4:0] cmd_in,
    input wire [7:0] imm_in,
    input wire [9:0] target_in,
    input wire [9:0] pc_out,
    input wire [5:0] pointer_out,
    input wire [5:0] sp_out,
    input wire [3:0] psw_out,
    input wire [3:0] port0_oe_out,
    input wire [3:0] port8_oe_out,
    input wire [3:0] port10_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);

    wire taken = cmd_valid_in && !busy_out;

    property p_rst_state;
        $fell(rst_in) |-> pc_out == 10'h000 && psw_out[3:2] == 2'h0;
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("reset state");
    property p_rst_pins;
        $fell(rst_in) |-> port0_oe_out == 4'h0 && port8_oe_out == 4'h0 && port10_out == 4'hF;
    endproperty
    a_rst_pins: assert property (p_rst_pins)
        else $error("reset pins");
    property p_fetch_step;
        taken && cmd_in == `CMD_FETCH |=> ##1 pc_out == $past(pc_out) + 10'h001;
    endproperty
    a_fetch_step: assert property (p_fetch_step)
        else $error("fetch pc");
    property p_ptr_low;
        taken && cmd_in == `CMD_LD_LOW |-> ##2 pointer_out[3:0] == ($past(imm_in, 2) & 8'h0F)
            && pointer_out[5:4] == ($past(pointer_out) >> 4);
    endproperty
    a_ptr_low: assert property (p_ptr_low)
        else $error("low load");
    property p_ptr_inc;
        taken && cmd_in == `CMD_RD_PTR_INC |-> ##2 pointer_out == $past(pointer_out) + 6'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc)
        else $error("ptr inc");
    property p_call_seq;
        taken && cmd_in == `CMD_CALL |=> busy_out[*5] ##1 !busy_out
            ##1 (pc_out == $past(target_in, 7) && sp_out == $past(sp_out, 6) - 6'h04);
    endproperty
    a_call_seq: assert property (p_call_seq)
        else $error("call");
    property p_ret_seq;
        taken && cmd_in == `CMD_RET |=> busy_out[*4] ##1 !busy_out
            ##1 (sp_out == $past(sp_out, 5) + 6'h04 && psw_out == $past(psw_out, 5));
    endproperty
    a_ret_seq: assert property (p_ret_seq)
        else $error("return");
    property p_psw_zero;
        psw_out[1] == 1'b0;
    endproperty
    a_psw_zero: assert property (p_psw_zero)
        else $error("psw zero");
    property p_port0_drive;
        (port0_oe_out & 4'hB) == 4'h0;
    endproperty
    a_port0_drive: assert property (p_port0_drive)
        else $error("port0 drive");
endmodule // datapath_props

bind mcu_core_datapath datapath_props u_props (.*);

/* test/pin_side_model.sv */
`timescale 1ns/1ps

module pin_side_model (
    input  wire       clock_in,
    input  wire [3:0] port0_out,
    input  wire [3:0] port0_oe_out,
    input  wire [3:0] port10_out,
    input  wire [3:0] port10_oe_out,
    input  wire [3:0] port11_out,
    input  wire [3:0] port11_oe_out,
    output wire [3:0] port0_in,
    output wire [3:0] port10_in,
    output wire [3:0] port11_in
);
    reg [3:0] pins_q = 4'h2;

    assign port0_in  = (pins_q & ~port0_oe_out) | (port0_out & port0_oe_out);
    // pull-up lifts released pins
    assign port10_in = ~port10_oe_out | port10_out;
    assign port11_in = ~port11_oe_out | port11_out;

    // peer: clock idles high, msb first
    task xfer(input [7:0] tx, output [7:0] rx);
        integer k;
        begin
            for (k = 7; k >= 0; k = k - 1) begin
                @(posedge clock_in);
                pins_q[3:1] <= {tx[k], pins_q[2], 1'b0};
                repeat (4) @(negedge clock_in);
                rx[k] = port0_in[2];
                @(posedge clock_in);
                pins_q[1] <= 1'b1;
                repeat (3) @(posedge clock_in);
            end
            pins_q[3] <= ~tx[0];
        end
    endtask
endmodule // pin_side_model

/* test/test_four_bit_mcu_core_datapath.sv */
`timescale 1ns/1ps
`include "mcu_core_map.vh"

module test_four_bit_mcu_core_datapath;
    reg        clock_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, rom_wr_en_in = 1'b0;
    reg  [4:0] cmd_in = 5'h00;
    reg  [7:0] imm_in = 8'h00, rom_wr_data_in = 8'h00, rx;
    reg  [9:0] target_in = 10'h000, rom_wr_addr_in = 10'h000, pc_m;
    reg  [3:0] alu_op_in = 4'h0;
    reg  [7:0] rom_m [0:1023];
    wire [3:0] port0_in, port10_in, port11_in, acc_out, psw_out, mem_data_out;
    wire [3:0] port0_out, port0_oe_out, port8_out, port8_oe_out;
    wire [3:0] port10_out, port10_oe_out, port11_out, port11_oe_out;
    wire [7:0] instr_out;
    wire [9:0] pc_out;
    wire [5:0] pointer_out, sp_out;
    wire       busy_out, serial_mode_out, serial_done_out;
    integer    errors = 0, checked = 0, seed = 59983, k, a, m, r;

    mcu_core_datapath DUT (.*);
    pin_side_model pm (.*);

    always #5 clock_in = ~clock_in;

    ////////////////////////////////////////////////////////////////
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task cmd(input [4:0] c, input [7:0] i, input [9:0] t, input [3:0] o);
        begin
            @(posedge clock_in);
            {cmd_in, imm_in, target_in, alu_op_in, cmd_valid_in} <= {c, i, t, o, 1'b1};
            @(posedge clock_in);
            cmd_valid_in <= 1'b0;
            @(negedge clock_in);
            while (busy_out === 1'b1)
                @(negedge clock_in);
            @(negedge clock_in);
        end
    endtask

    task op(input [4:0] c, input [7:0] i);
        cmd(c, i, 10'h000, 4'h0);
    endtask

    task test_done;
        begin
            $display("checks %0d mismatches %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors = errors + 1;
        test_done;
    end

    initial begin
        repeat (15) @(posedge clock_in);
        chk("p0 rst", port0_oe_out, 4'h0);
        @(posedge clock_in);
        rst_in <= 1'b0;
        @(negedge clock_in);
        chk("pc", pc_out, 10'h000);
        chk("skips", psw_out[3:2], 2'h0);
        chk("p0 drive", port0_oe_out, 4'h0);
        chk("p8 drive", port8_oe_out, 4'h0);
        chk("p10", {port10_oe_out, port10_out}, 8'h0F);
        chk("p11", {port11_oe_out, port11_out}, 8'h0F);
        $display("test reset done");
        for (k = 0; k < 1024; k = k + 1) begin
            @(posedge clock_in);
            r = $random(seed);
            rom_m[k] = r[7:0];
            {rom_wr_en_in, rom_wr_addr_in, rom_wr_data_in} <= {1'b1, k[9:0], r[7:0]};
        end
        @(posedge clock_in);
        rom_wr_en_in <= 1'b0;
        pc_m = 10'h000;
        for (k = 0; k < 8; k = k + 1) begin
            if (k == 3) begin
                pc_m = 10'h3FE;
                cmd(`CMD_JUMP, 8'h00, pc_m, 4'h0);
            end
            op(`CMD_FETCH, 8'h00);
            chk("instr", instr_out, rom_m[pc_m]);
            pc_m = pc_m + 10'h001;
            chk("pc step", pc_out, pc_m);
        end
        $display("test program store done");
        for (k = 0; k < 6; k = k + 1) begin
            a = $random(seed) & 63;
            m = $random(seed) & 15;
            op(`CMD_LD_ACC, m[7:0]);
            op(`CMD_WR_DIR, a[7:0]);
            op(`CMD_LD_HIGH, a[11:4]);
            op(`CMD_LD_LOW, a[7:0]);
            op(`CMD_LD_ACC, ~m[7:0]);
            op(`CMD_RD_PTR, 8'h00);
            chk("pointer", pointer_out, a);
            chk("ram via ptr", {mem_data_out, acc_out}, m * 17);
        end
        op(`CMD_LD_HIGH, 8'h03);
        op(`CMD_LD_LOW, 8'h0F);
        op(`CMD_SKIP_CLR, 8'h00);
        op(`CMD_RD_PTR_INC, 8'h00);
        chk("ptr wrap up", {pointer_out, psw_out[2]}, 7'h01);
        op(`CMD_SKIP_CLR, 8'h00);
        op(`CMD_RD_PTR_DEC, 8'h00);
        chk("ptr wrap down", {pointer_out, psw_out[2]}, 7'h7F);
        $display("test data memory done");
        op(`CMD_LD_HIGH, 8'h00);
        op(`CMD_LD_LOW, 8'h05);
        op(`CMD_LD_ACC, 8'h02);
        op(`CMD_WR_PTR, 8'h00);
        op(`CMD_LD_ACC, 8'h08);
        op(`CMD_SP_LOAD, 8'h00);
        chk("sp load", sp_out, 6'h28);
        a = pc_out;
        r = psw_out;
        cmd(`CMD_CALL, 8'h00, 10'h155, 4'h0);
        chk("call pc", pc_out, 10'h155);
        chk("call sp", sp_out, 6'h24);
        for (k = 1; k < 5; k = k + 1) begin
            op(`CMD_RD_DIR, 8'h28 - k[7:0]);
            chk("saved", acc_out, (k == 4) ? r : (a >> (12 - 4 * k)) & 15);
        end
        op(`CMD_LD_ACC, 8'h00);
        r = psw_out;
        op(`CMD_RET, 8'h00);
        chk("ret pc", pc_out, a);
        chk("ret psw", psw_out, r);
        chk("ret sp", sp_out, 6'h28);
        $display("test stack done");
        op(`CMD_LD_LOW, 8'h09);
        for (k = 0; k < 11; k = k + 1) begin
            a = $random(seed) & 15;
            m = (k == 6) ? a : $random(seed) & 15;
            op(`CMD_LD_ACC, m[7:0]);
            op(`CMD_WR_PTR, 8'h00);
            op(`CMD_LD_ACC, a[7:0]);
            cmd(`CMD_ALU, 8'h00, 10'h000, `ALU_CLRC);
            op(`CMD_SKIP_CLR, 8'h00);
            cmd(`CMD_ALU, a[7:0], 10'h000, k[3:0]);
            r = (k == 0) ? a + m : (k == 1) ? a & m : (k == 2) ? a | m : (k == 3) ? a ^ m
              : (k == 4) ? a + 1 : (k == 5) ? a + 15 : a;
            chk("alu acc", acc_out, r & 15);
            chk("alu mem", mem_data_out, k == 7 ? m | 1 << a % 4
                : k == 8 ? m & ~(1 << a % 4) & 15 : m);
            chk("alu psw", psw_out[2:0], ((k == 0 && r > 15) || k == 6 || (k == 4 && a == 15)
                || (k == 5 && a == 0)) * 4 + ((k == 0 && r > 15) || k == 9));
        end
        op(`CMD_LD_ACC, 8'h0F);
        op(`CMD_WR_PTR, 8'h00);
        cmd(`CMD_ALU, 8'h00, 10'h000, `ALU_CLRC);
        op(`CMD_PAIR_INC, 8'h00);
        chk("pair inc", {mem_data_out, acc_out, psw_out[0]}, 9'h001);
        $display("test alu done");
        a = $random(seed) & 15;
        op(`CMD_LD_LOW, 8'h08);
        op(`CMD_LD_ACC, a[7:0]);
        op(`CMD_PORT_WR, 8'h00);
        chk("p8", {port8_oe_out, port8_out}, 8'hF0 | a);
        op(`CMD_LD_LOW, 8'h05);
        op(`CMD_PORT_BSET, 8'h00);
        chk("p8 bit", port8_out, a | 2);
        op(`CMD_LD_LOW, 8'h0A);
        op(`CMD_LD_ACC, 8'h05);
        op(`CMD_PORT_WR, 8'h00);
        op(`CMD_LD_ACC, 8'h00);
        op(`CMD_PORT_RD, 8'h00);
        chk("p10", {port10_oe_out, acc_out}, 8'hA5);
        op(`CMD_LD_LOW, 8'h0E);
        op(`CMD_PORT_BCLR, 8'h00);
        chk("p11 bit", port11_oe_out, 4'h4);
        @(posedge clock_in);
        pm.pins_q <= a[3:0] | 4'h2;
        op(`CMD_LD_LOW, 8'h00);
        op(`CMD_PORT_RD, 8'h00);
        chk("p0", acc_out, a | 2);
        $display("test ports done");
        op(`CMD_LD_LOW, 8'h01);
        op(`CMD_LD_ACC, 8'h01);
        op(`CMD_PORT_WR, 8'h00);
        chk("serial mode", {serial_mode_out, port0_oe_out}, 5'h14);
        m = $random(seed) & 255;
        a = $random(seed) & 255;
        for (k = 2; k < 4; k = k + 1) begin
            op(`CMD_LD_LOW, k[7:0]);
            op(`CMD_LD_ACC, m >> (4 * k - 8));
            op(`CMD_PORT_WR, 8'h00);
        end
        pm.xfer(a[7:0], rx);
        repeat (4) @(negedge clock_in);
        chk("serial out", {serial_done_out, rx}, 256 + m);
        for (k = 2; k < 4; k = k + 1) begin
            op(`CMD_LD_LOW, k[7:0]);
            op(`CMD_PORT_RD, 8'h00);
            chk("serial in", acc_out, (a >> (4 * k - 8)) & 15);
        end
        $display("test serial done");
        test_done;
    end
endmodule // test_four_bit_mcu_core_datapath
